// File: pkg/sadc_defs.svh
// Named constants for the converter sequencer: field widths, timing counts and codes.
`ifndef SADC_DEFS_SVH
`define SADC_DEFS_SVH

// ***************************************************************
// Widths
// ***************************************************************
`define SADC_RES_W        10
`define SADC_CH_W         4
`define SADC_REF_W        2
`define SADC_PS_W         3
`define SADC_TS_W         3
`define SADC_PRE_W        7
`define SADC_HALF_W       6

// ***************************************************************
// Channel codes: eight pins, then bandgap and ground
// ***************************************************************
`define SADC_CH_PIN_LAST  4'h7
`define SADC_CH_BANDGAP   4'he
`define SADC_CH_GROUND    4'hf

// ***************************************************************
// Conversion timing in half converter clock cycles
// ***************************************************************
`define SADC_NORM_TOTAL   6'h1a
`define SADC_NORM_SH      6'h03
`define SADC_FIRST_TOTAL  6'h32
`define SADC_FIRST_SH     6'h1b
`define SADC_AUTO_TOTAL   6'h1b
`define SADC_AUTO_SH      6'h04
`define SADC_HALF_ONE     6'h01
`define SADC_HALF_LASTCYC 6'h02

// ***************************************************************
// Trigger handling
// ***************************************************************
`define SADC_TS_FREE_RUN  3'h0
`define SADC_TRIG_SYNC    3

// ***************************************************************
// Prescaler
// ***************************************************************
`define SADC_PRE_MIN_MASK 7'h01
`define SADC_PRE_ONE      7'h01
`define SADC_PRE_ZERO     7'h00
`define SADC_PS_MIN       3'h1

// ***************************************************************
// Reset values
// ***************************************************************
`define SADC_RES_RST      10'h000
`define SADC_BYTE_RST     8'h00
`define SADC_HALF_RST     6'h00

`endif

// File: pkg/sadc_pkg.sv
// Types shared by the converter sequencer.
package sadc_pkg;

  typedef enum logic [2:0]
  {
    SADC_IDLE = 3'b001,
    SADC_WAIT = 3'b010,
    SADC_CONV = 3'b100
  } sadc_state_t;

  typedef struct packed
  {
    logic [1:0] reference;
    logic [3:0] channel;
  } sadc_sel_t;

  typedef struct packed
  {
    logic [7:0] high;
    logic [7:0] low;
  } sadc_bytes_t;

endpackage

// File: core/sadc_sequencer.sv
// Sequencer for a 10-bit successive approximation converter.
`timescale 1ns/1ps
`include "sadc_defs.svh"

// Overview of operation
// - Selections take effect only while enable set.
// - Channels: eight pins, ground, bandgap.
// - Result right aligned, left when bit set.
// - Low byte read locks updates until high.
// - Complete flag set even if result discarded.
// - Start bit begins conversion, clears at end.
// - Channel change waits for running conversion.
// - Trigger rising edge resets prescaler, starts.
// - Trigger edges ignored unless idle three cycles later.
// - Flags set always; software clears trigger flag.
// - Complete flag source restarts, start stays high.
// - Start bit reads one during any conversion.
// - Prescaler held reset while enable clear.
// - Software start waits next converter rising edge.
// - Conversion 13 cycles, first one 25.
// - Sample strobe at 1.5, first at 13.5.
// - Completion writes result, sets flag, clears start.
// - Auto: sample at 2, total 13.5, sync 3.
// - Differential auto-trigger except complete flag source: every triggered conversion 25 cycles.
// - Selection buffered, locked during conversion, resumes last.
module sadc_sequencer
(
  input  wire logic                      ref_clk,
  input  wire logic                      sys_rst,
  input  wire logic                      clk_en,
  input  wire logic                      converter_enable,
  input  wire logic                      auto_trigger_enable,
  input  wire logic [`SADC_TS_W-1:0]     trigger_source_select,
  input  wire logic [7:0]                trigger_sources,
  input  wire logic                      differential_mode,
  input  wire logic [`SADC_PS_W-1:0]     prescale_select,
  input  wire logic                      left_align_result,
  input  wire logic                      start_write,
  input  wire logic                      sel_write,
  input  wire logic [`SADC_CH_W-1:0]     channel_select_bits,
  input  wire logic [`SADC_REF_W-1:0]    reference_select_bits,
  input  wire logic                      flag_clear,
  input  wire logic                      result_low_read,
  input  wire logic                      result_high_read,
  input  wire logic [`SADC_RES_W-1:0]    sar_data,
  output logic                           start_conversion_bit,
  output logic                           conversion_complete_flag,
  output logic [7:0]                     result_low_byte,
  output logic [7:0]                     result_high_byte,
  output logic [`SADC_CH_W-1:0]          active_channel,
  output logic [`SADC_REF_W-1:0]         active_reference,
  output logic                           analog_enable,
  output logic                           sample_hold,
  output logic                           converting
);

  // ***************************************************************
  // Functions
  // ***************************************************************
  function automatic logic [`SADC_PRE_W-1:0] pre_mask(input logic [`SADC_PS_W-1:0] ps);
    logic [`SADC_PRE_W-1:0] m;
    m = `SADC_PRE_MIN_MASK;
    if (ps > `SADC_PS_MIN)
    begin
      m = (`SADC_PRE_ONE << ps) - `SADC_PRE_ONE;
    end
    return m;
  endfunction

  function automatic sadc_pkg::sadc_bytes_t align(input logic [`SADC_RES_W-1:0] r,
                                                   input logic                    left);
    sadc_pkg::sadc_bytes_t b;
    b = left ? {r, 6'h00} : {6'h00, r};
    return b;
  endfunction

  // ***************************************************************
  // State
  // ***************************************************************
  sadc_pkg::sadc_state_t      state_r;
  sadc_pkg::sadc_state_t      state_nxt;
  logic [`SADC_PRE_W-1:0]     pre_r;
  logic [`SADC_PRE_W-1:0]     pre_nxt;
  logic [`SADC_HALF_W-1:0]    half_r;
  logic [`SADC_HALF_W-1:0]    half_nxt;
  logic [`SADC_HALF_W-1:0]    total_r;
  logic [`SADC_HALF_W-1:0]    total_nxt;
  logic [`SADC_HALF_W-1:0]    sh_r;
  logic [`SADC_HALF_W-1:0]    sh_nxt;
  logic                       init_pend_r;
  logic                       trig_prev_r;
  logic [`SADC_TRIG_SYNC-1:0] trig_pipe_r;
  logic                       lock_r;
  logic [`SADC_RES_W-1:0]     result_r;
  sadc_pkg::sadc_sel_t        hold_sel_r;
  sadc_pkg::sadc_sel_t        work_sel_r;

  // ***************************************************************
  // Decoding
  // ***************************************************************
  wire [`SADC_PRE_W-1:0] mask      = pre_mask(prescale_select);
  wire                   adc_rise  = converter_enable && (pre_r == mask);
  wire                   adc_fall  = converter_enable && (pre_r == (mask >> 1));
  wire                   half_tick = adc_rise || adc_fall;
  wire                   free_run  = auto_trigger_enable &&
                                     (trigger_source_select == `SADC_TS_FREE_RUN);
  wire                   trig_lvl  = trigger_sources[trigger_source_select];
  // The delayed edge (trig_fire) is qualified by idle, so an edge whose delayed copy emerges during a conversion is dropped.
  wire                   trig_edge = auto_trigger_enable && !free_run && trig_lvl &&
                                     !trig_prev_r;
  wire                   trig_fire = trig_pipe_r[`SADC_TRIG_SYNC-1] &&
                                     (state_r == sadc_pkg::SADC_IDLE);
  wire                   sw_go     = (state_r == sadc_pkg::SADC_WAIT) && adc_rise;
  wire                   in_conv   = (state_r == sadc_pkg::SADC_CONV);
  wire                   conv_done = in_conv && half_tick &&
                                     ((half_r + `SADC_HALF_ONE) == total_r);
  wire                   last_cyc  = in_conv && ((half_r + `SADC_HALF_LASTCYC) >= total_r);
  wire                   sel_open  = converter_enable &&
                                     ((state_r != sadc_pkg::SADC_CONV) || last_cyc);
  wire                   restart   = conv_done && free_run;
  wire                   diff_init = differential_mode && auto_trigger_enable && !free_run;
  wire                   store_ok  = conv_done && !lock_r;
  wire                   ch_legal  = (channel_select_bits <= `SADC_CH_PIN_LAST) ||
                                     (channel_select_bits == `SADC_CH_BANDGAP) ||
                                     (channel_select_bits == `SADC_CH_GROUND);
  wire [`SADC_RES_W-1:0]      res_src   = store_ok ? sar_data : result_r;
  wire sadc_pkg::sadc_bytes_t bytes_nxt = align(res_src, left_align_result);

  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb
  begin
    state_nxt = state_r;
    half_nxt  = half_r;
    total_nxt = total_r;
    sh_nxt    = sh_r;
    pre_nxt   = adc_rise ? `SADC_PRE_ZERO : pre_r + `SADC_PRE_ONE;
    if (!converter_enable || trig_fire)
    begin
      pre_nxt = `SADC_PRE_ZERO;
    end
    unique case (state_r)
      sadc_pkg::SADC_IDLE:
      begin
        if (trig_fire)
        begin
          state_nxt = sadc_pkg::SADC_CONV;
          half_nxt  = `SADC_HALF_RST;
          total_nxt = (init_pend_r || diff_init) ? `SADC_FIRST_TOTAL
                                                 : `SADC_AUTO_TOTAL;
          sh_nxt    = (init_pend_r || diff_init) ? `SADC_FIRST_SH : `SADC_AUTO_SH;
        end
        else if (start_write && converter_enable)
        begin
          state_nxt = sadc_pkg::SADC_WAIT;
        end
      end
      sadc_pkg::SADC_WAIT:
      begin
        if (sw_go)
        begin
          state_nxt = sadc_pkg::SADC_CONV;
          half_nxt  = `SADC_HALF_RST;
          total_nxt = init_pend_r ? `SADC_FIRST_TOTAL : `SADC_NORM_TOTAL;
          sh_nxt    = init_pend_r ? `SADC_FIRST_SH : `SADC_NORM_SH;
        end
      end
      sadc_pkg::SADC_CONV:
      begin
        if (half_tick)
        begin
          half_nxt = half_r + `SADC_HALF_ONE;
        end
        if (restart)
        begin
          half_nxt  = `SADC_HALF_RST;
          total_nxt = `SADC_NORM_TOTAL;
          sh_nxt    = `SADC_NORM_SH;
        end
        else if (conv_done)
        begin
          state_nxt = sadc_pkg::SADC_IDLE;
        end
      end
      default:
      begin
        state_nxt = sadc_pkg::SADC_IDLE;
      end
    endcase
    if (!converter_enable)
    begin
      state_nxt = sadc_pkg::SADC_IDLE;
    end
  end

  // ***************************************************************
  // Sequencing registers
  // ***************************************************************
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state_r     <= sadc_pkg::SADC_IDLE;
      pre_r       <= `SADC_PRE_ZERO;
      half_r      <= `SADC_HALF_RST;
      total_r     <= `SADC_NORM_TOTAL;
      sh_r        <= `SADC_NORM_SH;
      init_pend_r <= 1'b1;
      trig_prev_r <= 1'b0;
      trig_pipe_r <= '0;
    end
    else if (clk_en)
    begin
      state_r     <= state_nxt;
      pre_r       <= pre_nxt;
      half_r      <= half_nxt;
      total_r     <= total_nxt;
      sh_r        <= sh_nxt;
      trig_prev_r <= trig_lvl;
      // Three cycles of delay keep the trigger-to-sample latency fixed.
      trig_pipe_r <= {trig_pipe_r[`SADC_TRIG_SYNC-2:0], trig_edge};
      if (!converter_enable)
      begin
        init_pend_r <= 1'b1;
      end
      else if (state_nxt == sadc_pkg::SADC_CONV)
      begin
        init_pend_r <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // Result, flag and start bit
  // ***************************************************************
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      start_conversion_bit     <= 1'b0;
      conversion_complete_flag <= 1'b0;
      lock_r                   <= 1'b0;
      result_r                 <= `SADC_RES_RST;
      result_low_byte          <= `SADC_BYTE_RST;
      result_high_byte         <= `SADC_BYTE_RST;
      sample_hold              <= 1'b0;
    end
    else if (clk_en)
    begin
      if (state_nxt != sadc_pkg::SADC_IDLE)
      begin
        start_conversion_bit <= 1'b1;
      end
      else
      begin
        start_conversion_bit <= 1'b0;
      end
      // A completion in the same cycle as a clear leaves the flag set.
      if (conv_done)
      begin
        conversion_complete_flag <= 1'b1;
      end
      else if (flag_clear)
      begin
        conversion_complete_flag <= 1'b0;
      end
      if (store_ok)
      begin
        result_r <= sar_data;
      end
      if (result_high_read)
      begin
        lock_r <= 1'b0;
      end
      else if (result_low_read)
      begin
        lock_r <= 1'b1;
      end
      result_low_byte  <= bytes_nxt.low;
      result_high_byte <= bytes_nxt.high;
      sample_hold      <= in_conv && half_tick &&
                          ((half_r + `SADC_HALF_ONE) == sh_r);
    end
  end

  // ***************************************************************
  // Selection buffering
  // ***************************************************************
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      hold_sel_r       <= '0;
      work_sel_r       <= '0;
      active_channel   <= '0;
      active_reference <= '0;
      analog_enable    <= 1'b0;
      converting       <= 1'b0;
    end
    else if (clk_en)
    begin
      // Reserved channel codes are refused so the mux never sees them.
      if (sel_write && ch_legal)
      begin
        hold_sel_r <= {reference_select_bits, channel_select_bits};
      end
      if (sel_open)
      begin
        work_sel_r <= hold_sel_r;
      end
      active_channel   <= work_sel_r.channel;
      active_reference <= work_sel_r.reference;
      analog_enable    <= converter_enable;
      converting       <= (state_nxt == sadc_pkg::SADC_CONV);
    end
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  pre_held_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && !converter_enable |=> pre_r == `SADC_PRE_ZERO)
    else $error("prescaler ran while disabled");

  lock_keep_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && conv_done && lock_r |=> $stable(result_r))
    else $error("locked result was overwritten");

  flag_disc_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && conv_done |=> conversion_complete_flag)
    else $error("complete flag missing after conversion");

  start_busy_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    in_conv |-> start_conversion_bit)
    else $error("start bit low during conversion");

  start_clear_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && conv_done && !free_run && converter_enable |=> !start_conversion_bit)
    else $error("start bit not cleared at completion");

  free_run_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && restart && converter_enable |=> in_conv && half_r == `SADC_HALF_RST)
    else $error("free running did not restart");

  trig_ignore_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && in_conv && trig_pipe_r[`SADC_TRIG_SYNC-1] && !conv_done && converter_enable
    |=> in_conv && half_r >= $past(half_r))
    else $error("trigger edge restarted a running conversion");

  trig_start_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && trig_fire && converter_enable |=> in_conv && pre_r == `SADC_PRE_ZERO)
    else $error("trigger did not start conversion");

  sel_lock_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && in_conv && !last_cyc |=> $stable(work_sel_r))
    else $error("selection changed mid conversion");

  sw_edge_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && state_r == sadc_pkg::SADC_WAIT && !adc_rise && converter_enable
    |=> state_r == sadc_pkg::SADC_WAIT)
    else $error("software start left wait early");

endmodule

// File: sim/sadc_analog_model.sv
// Behavioural model of the analog sample-and-hold and comparator behind the sequencer.
`timescale 1ns/1ps
`include "sadc_defs.svh"
module sadc_analog_model
#(
  parameter logic [`SADC_RES_W-1:0] BANDGAP_CODE = 10'h2c5
)
(
  input  wire logic                   ref_clk,
  input  wire logic                   analog_enable,
  input  wire logic                   sample_hold,
  input  wire logic [`SADC_CH_W-1:0]  active_channel,
  input  wire logic [`SADC_RES_W-1:0] pin_level,
  output logic      [`SADC_RES_W-1:0] sar_data
);
  // ********************
  // Sample-and-hold
  // ********************
  // Each pin reads its level plus its own number, so a wrong channel shows in the code.
  logic [`SADC_RES_W-1:0] held_r = 10'h155;
  logic [`SADC_RES_W-1:0] pin_code;

  assign pin_code = pin_level + {6'h00, active_channel};
  assign sar_data = held_r;

  // While powered down the array floats, so the output changes every cycle.
  always @(posedge ref_clk)
  begin
    if (!analog_enable)
      held_r <= ~held_r;
    else if (sample_hold && active_channel == `SADC_CH_GROUND)
      held_r <= 10'h000;
    else if (sample_hold && active_channel == `SADC_CH_BANDGAP)
      held_r <= BANDGAP_CODE;
    else if (sample_hold)
      held_r <= pin_code;
  end
endmodule

// File: sim/sar_adc_sequencer_test.sv
// Self-checking bench: the sequencer against a reference model kept in the bench.
`timescale 1ns/1ps
module sar_adc_sequencer_test;
  // ********************
  // Stimulus and reference state
  // ********************
  localparam logic [9:0] BANDGAP = 10'h2c5;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        clk_en = 1'b1;
  logic        converter_enable = 1'b0;
  logic        auto_trigger_enable = 1'b0;
  logic        differential_mode = 1'b0;
  logic        left_align_result = 1'b0;
  logic        start_write = 1'b0;
  logic        sel_write = 1'b0;
  logic        flag_clear = 1'b0;
  logic        result_low_read = 1'b0;
  logic        result_high_read = 1'b0;
  logic [2:0]  trigger_source_select = 3'h3;
  logic [2:0]  prescale_select = 3'h2;
  logic [7:0]  trigger_sources = 8'h00;
  logic [3:0]  channel_select_bits = 4'h0;
  logic [1:0]  reference_select_bits = 2'h0;
  logic [9:0]  pin_level = 10'h000;
  logic [9:0]  sar_data;
  logic [7:0]  result_low_byte;
  logic [7:0]  result_high_byte;
  logic [3:0]  active_channel;
  logic [1:0]  active_reference;
  logic        start_conversion_bit;
  logic        conversion_complete_flag;
  logic        analog_enable;
  logic        sample_hold;
  logic        converting;
  logic [31:0] rng = 32'h42;
  logic [9:0]  exp_raw = 10'h000;
  logic [3:0]  pend_ch = 4'h0;
  logic [1:0]  pend_rf = 2'h0;
  int          bad_count = 0;
  int          comparisons = 0;
  int          cycle = 0;
  int          div = 4;

  sadc_sequencer u_dut
  (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en), .converter_enable(converter_enable),
    .auto_trigger_enable(auto_trigger_enable), .trigger_source_select(trigger_source_select),
    .trigger_sources(trigger_sources), .differential_mode(differential_mode),
    .prescale_select(prescale_select), .left_align_result(left_align_result),
    .start_write(start_write), .sel_write(sel_write), .channel_select_bits(channel_select_bits),
    .reference_select_bits(reference_select_bits), .flag_clear(flag_clear),
    .result_low_read(result_low_read), .result_high_read(result_high_read), .sar_data(sar_data),
    .start_conversion_bit(start_conversion_bit), .conversion_complete_flag(conversion_complete_flag),
    .result_low_byte(result_low_byte), .result_high_byte(result_high_byte),
    .active_channel(active_channel), .active_reference(active_reference),
    .analog_enable(analog_enable), .sample_hold(sample_hold), .converting(converting)
  );

  sadc_analog_model #(.BANDGAP_CODE(BANDGAP)) u_analog
  (
    .ref_clk(ref_clk), .analog_enable(analog_enable), .sample_hold(sample_hold),
    .active_channel(active_channel), .pin_level(pin_level), .sar_data(sar_data)
  );

  always #5 ref_clk = ~ref_clk;

  // The ceiling sits well above the slowest prescaler sweep.
  always @(posedge ref_clk)
  begin
    cycle++;
    if (cycle == 20000)
    begin
      bad_count++;
      test_done();
    end
  end

  // ********************
  // Helpers
  // ********************
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic [9:0] analog_value(input logic [3:0] ch, input logic [9:0] lvl);
    if (ch == 4'hf) return 10'h000;
    if (ch == 4'he) return BANDGAP;
    return lvl + {6'h00, ch};
  endfunction

  function automatic logic [15:0] expect_bytes(input logic [9:0] raw, input logic left);
    if (left) return {raw, 6'h00};
    return {6'h00, raw};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic check_cycles(input int got, input int exp, input string what);
    comparisons++;
    if (got != exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s took %0d cycles, expected %0d", $time, what, got, exp);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic draw();
    rng = xorshift(rng);
    pin_level = rng[9:0];
    left_align_result = rng[10];
  endtask

  // Codes 8 to d are refused, so the reference model keeps the old choice for them.
  task automatic select_input(input logic [3:0] ch, input logic [1:0] rf);
    channel_select_bits = ch;
    reference_select_bits = rf;
    sel_write = 1'b1;
    if (ch < 4'h8 || ch > 4'hd) {pend_rf, pend_ch} = {rf, ch};
    tick(1);
    sel_write = 1'b0;
  endtask

  task automatic soft_start();
    flag_clear = 1'b1;
    start_write = 1'b1;
    tick(1);
    flag_clear = 1'b0;
    start_write = 1'b0;
  endtask

  task automatic fire_trigger();
    trigger_sources = 8'h00;
    flag_clear = 1'b1;
    tick(1);
    flag_clear = 1'b0;
    trigger_sources = 8'h08;
  endtask

  // Times are in half converter clocks from the first cycle that shows converting.
  task automatic watch(input int tot_h, input int sh_h, input int max_wait, input logic locked,
                       input int mid);
    int t0;
    int t1;
    logic [9:0] raw;
    logic [15:0] exp_b;
    t0 = cycle;
    raw = analog_value(pend_ch, pin_level);
    while (converting !== 1'b1 && cycle - t0 < max_wait)
      tick(1);
    check_val(32'(converting), 32'h1, "conversion begun");
    check_val(32'(start_conversion_bit), 32'h1, "start bit in conversion");
    t0 = cycle;
    while (sample_hold !== 1'b1 && cycle - t0 < 1000)
      tick(1);
    t1 = cycle - t0;
    if (sh_h > 0) check_cycles(t1, sh_h * div / 2, "sample instant");
    check_val(32'({active_reference, active_channel}), 32'({pend_rf, pend_ch}),
              "sampled input");
    if (mid == 1) select_input(pend_ch ^ 4'h1, 2'h0);
    if (mid == 2)
    begin
      trigger_sources = 8'h00;
      tick(1);
      trigger_sources = 8'h08;
    end
    while (conversion_complete_flag !== 1'b1 && cycle - t0 < 4000)
      tick(1);
    if (tot_h > 0)
      check_cycles(cycle - t0, tot_h * div / 2, "conversion");
    check_val(32'({conversion_complete_flag, start_conversion_bit}), 32'h2,
              "end");
    // The bytes must already hold the result in the cycle that shows the flag.
    if (!locked) exp_raw = raw;
    exp_b = expect_bytes(exp_raw, left_align_result);
    check_val(32'({result_high_byte, result_low_byte}), 32'(exp_b),
              "result");
    tick(1);
  endtask

  // ********************
  // Scenarios
  // ********************
  initial
  begin
    int n;
    int ps;
    int chans [10];
    chans = '{0, 1, 2, 3, 4, 5, 6, 7, 14, 15};
    tick(8);
    sys_rst = 1'b0;
    tick(1);
    check_val(32'({start_conversion_bit, conversion_complete_flag, result_high_byte,
                   result_low_byte, active_channel, analog_enable, converting}), 32'h0, "reset");
    select_input(4'h3, 2'h1);
    soft_start();
    tick(10);
    check_val(32'({converting, active_channel}), 32'h0, "off");
    converter_enable = 1'b1;
    tick(3);
    check_val(32'({active_reference, active_channel}), 32'h13, "on");
    soft_start();
    watch(50, 27, div + 2, 1'b0, 0);
    result_low_read = 1'b1;
    tick(1);
    result_low_read = 1'b0;
    draw();
    soft_start();
    watch(26, 3, div + 2, 1'b1, 0);
    result_high_read = 1'b1;
    tick(1);
    result_high_read = 1'b0;
    soft_start();
    watch(26, 3, div + 2, 1'b0, 1);
    check_val(32'({active_reference, active_channel}), 32'({pend_rf, pend_ch}),
              "channel switched");
    select_input(4'h9, 2'h2);
    tick(2);
    check_val(32'(active_channel), 32'(pend_ch), "reserved code");
    auto_trigger_enable = 1'b1;
    fire_trigger();
    watch(27, 4, 2 * div + 8, 1'b0, 2);
    n = 0;
    repeat (40)
    begin
      tick(1);
      if (converting === 1'b1) n++;
    end
    check_cycles(n, 0, "held or late trigger");
    differential_mode = 1'b1;
    fire_trigger();
    watch(50, 0, 2 * div + 8, 1'b0, 0);
    differential_mode = 1'b0;
    soft_start();
    watch(0, 0, div + 2, 1'b0, 0);
    trigger_source_select = 3'h0;
    soft_start();
    repeat (3)
    begin
      n = 0;
      while (sample_hold !== 1'b1 && n < 200)
      begin
        tick(1);
        n++;
      end
      check_val(32'({sample_hold, start_conversion_bit}), 32'h3, "free run");
      tick(1);
    end
    converter_enable = 1'b0;
    tick(2);
    check_val(32'({start_conversion_bit, converting, analog_enable}), 32'h0,
              "disabled");
    auto_trigger_enable = 1'b0;
    trigger_source_select = 3'h3;
    prescale_select = 3'h0;
    div = 2;
    tick(5);
    // With the clock enable low, enabling and starting must leave analog enable, start bit and converting low.
    clk_en = 1'b0;
    converter_enable = 1'b1;
    soft_start();
    tick(4);
    check_val(32'({analog_enable, start_conversion_bit, converting}), 32'h0,
              "frozen");
    clk_en = 1'b1;
    soft_start();
    watch(50, 27, div + 2, 1'b0, 0);
    // Ratios never fall here: a falling ratio may leave the counter past its new wrap.
    for (int i = 0; i < 10; i++)
    begin
      ps = (i < 3) ? 0 : i - 2;
      prescale_select = 3'(ps);
      div = (ps < 2) ? 2 : (1 << ps);
      draw();
      select_input(4'(chans[i]), rng[12:11]);
      soft_start();
      watch(26, 3, div + 2, 1'b0, 0);
    end
    test_done();
  end
endmodule
